//--- hw/pcr_program_counter.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_program_counter #(
  parameter int HOLD_TICKS = pcr_pkg::HOLD_TICKS
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        MASTER_CLEAR_PIN,
  input  wire logic        RC_OSC_PIN,
  input  wire logic        WATCHDOG_TIMEOUT,
  input  wire logic [11:0] INSTR_WORD,
  input  wire logic [7:0]  ALU_RESULT,
  input  wire logic [1:0]  STATUS_PAGE,
  output logic      [10:0] PC,
  output logic      [7:0]  PC_LOW_BYTE,
  output logic             CORE_RST,
  output logic             CYCLE_STB
);
  // ---------------------------------------------------------------
  // Pin synchronisers: 0 = master clear, 1 = RC oscillator
  // ---------------------------------------------------------------
  logic [1:0] pin_in;
  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;

  assign pin_in = {RC_OSC_PIN, MASTER_CLEAR_PIN};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic [2:0] s_r, s_nxt;
      logic       l_r, l_nxt;
      always_comb begin
        s_nxt = {s_r[1:0], pin_in[gi]};
        // Only a level seen by stages 2 and 3 counts
        l_nxt = (s_r[1] == s_r[2]) ? s_r[2] : l_r;
      end
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          s_r <= 3'h0;
          l_r <= 1'b0;
        end else begin
          s_r <= s_nxt;
          l_r <= l_nxt;
        end
      end
      assign pin_lvl[gi]  = l_r;
      assign pin_rise[gi] = l_nxt & ~l_r;
    end
  endgenerate

  logic clear_hi;
  logic rc_tick;
  assign clear_hi = pin_lvl[0];
  assign rc_tick = pin_rise[1];

  // ---------------------------------------------------------------
  // Reset hold timer
  // ---------------------------------------------------------------
  logic hold_busy;

  pcr_hold_timer u_hold (
    .clk        (CLK),
    .rst        (SYS_RST),
    .tick       (rc_tick),
    .clear_hi   (clear_hi),
    .trig       (WATCHDOG_TIMEOUT),
    .hold_ticks (24'(HOLD_TICKS)),
    .busy       (hold_busy)
  );

  assign CORE_RST = hold_busy;

  // ---------------------------------------------------------------
  // Instruction cycle: four clocks per cycle
  // ---------------------------------------------------------------
  logic [1:0] q_r, q_nxt;
  logic       step;

  always_comb begin
    q_nxt = q_r + 2'h1;
    if (hold_busy) begin
      q_nxt = 2'h0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      q_r <= 2'h0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign step      = (q_r == pcr_pkg::Q_LAST) & ~hold_busy;
  assign CYCLE_STB = step;

  // ---------------------------------------------------------------
  // Decode of counter-loading instructions
  // ---------------------------------------------------------------
  logic is_jump;
  logic is_call;
  logic is_move_w;
  logic is_add_w;
  logic is_bit_set;
  logic low_wr;
  logic is_load;

  always_comb begin
    // Jump is 101k_kkkk_kkkk, call is 1001_kkkk_kkkk
    is_jump    = INSTR_WORD[11:9] == pcr_pkg::OPC_JUMP;
    is_call    = INSTR_WORD[11:8] == pcr_pkg::OPC_CALL;
    is_move_w  = INSTR_WORD[11:5] == pcr_pkg::OPC_MOVE_W &&
                 INSTR_WORD[4:0] == pcr_pkg::LOW_ADDR;
    // Add only loads when the result goes back to the file
    is_add_w   = INSTR_WORD[11:6] == pcr_pkg::OPC_ADD_W && INSTR_WORD[5] &&
                 INSTR_WORD[4:0] == pcr_pkg::LOW_ADDR;
    // Limitation: only bit 5 is decoded, other bit-sets of the low byte are not loads
    is_bit_set = INSTR_WORD[11:8] == pcr_pkg::OPC_BIT_SET &&
                 INSTR_WORD[7:5] == pcr_pkg::LOW_BIT &&
                 INSTR_WORD[4:0] == pcr_pkg::LOW_ADDR;
    low_wr     = is_move_w | is_add_w | is_bit_set;
    is_load    = is_jump | is_call | low_wr;
  end

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  logic [10:0] pc_r, pc_nxt;

  always_comb begin
    pc_nxt = pc_r;
    if (hold_busy) begin
      pc_nxt = pcr_pkg::PC_RST;
    end else if (step) begin
      if (is_jump) begin
        pc_nxt = {STATUS_PAGE, INSTR_WORD[8:0]};
      end else if (is_call) begin
        // Bit 8 cleared: targets limited to the lower 256 words of the selected page
        pc_nxt = {STATUS_PAGE, 1'b0, INSTR_WORD[7:0]};
      end else if (low_wr) begin
        pc_nxt = {STATUS_PAGE, 1'b0, ALU_RESULT};
      end else begin
        // Wraps at 11 bits and may carry into the page bits
        pc_nxt = pc_r + 11'h001;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pc_r <= pcr_pkg::PC_RST;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  assign PC          = pc_r;
  assign PC_LOW_BYTE = pc_r[7:0];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_incr;
    step && !is_load |=> PC == $past(PC) + 11'h001;
  endproperty
  a_incr: assert property (p_incr) else $error("no increment");

  property p_jump;
    step && is_jump |=> PC[8:0] == $past(INSTR_WORD[8:0]);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_pcl;
    PC_LOW_BYTE == PC[7:0];
  endproperty
  a_pcl: assert property (p_pcl) else $error("low byte mismatch");

  property p_page;
    step && is_load |=> PC[10:9] == $past(STATUS_PAGE);
  endproperty
  a_page: assert property (p_page) else $error("page bits wrong");

  property p_low;
    step && (is_call || low_wr) |=>
      PC[7:0] == ($past(is_call) ? $past(INSTR_WORD[7:0]) : $past(ALU_RESULT));
  endproperty
  a_low: assert property (p_low) else $error("low byte load wrong");

  property p_bit8;
    step && (is_call || low_wr) |=> !PC[8];
  endproperty
  a_bit8: assert property (p_bit8) else $error("bit 8 not cleared");

  property p_bitset;
    step && INSTR_WORD == 12'h5a2 |=> PC[7:0] == $past(ALU_RESULT);
  endproperty
  a_bitset: assert property (p_bitset) else $error("bit-set not a load");

  // Add with the result kept in the working register must not load
  property p_add_keep;
    step && INSTR_WORD[11:6] == pcr_pkg::OPC_ADD_W && !INSTR_WORD[5] |=>
      PC == $past(PC) + 11'h001;
  endproperty
  a_add_keep: assert property (p_add_keep) else $error("add to W loaded");

  property p_wrap;
    step && !is_load && PC == 11'h7ff |=> PC == 11'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at top");

  property p_stands;
    !step && !CORE_RST |=> $stable(PC);
  endproperty
  a_stands: assert property (p_stands) else $error("counter moved off cycle");

  property p_gap;
    CYCLE_STB |=> !CYCLE_STB [*3];
  endproperty
  a_gap: assert property (p_gap) else $error("cycle strobes too close");

  // ---------------------------------------------------------------
  // Checks: reset hold
  // ---------------------------------------------------------------
  property p_held;
    CORE_RST |-> !CYCLE_STB ##1 PC == pcr_pkg::PC_RST;
  endproperty
  a_held: assert property (p_held) else $error("core ran during hold");

  property p_quiet;
    CORE_RST |=> q_r == 2'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("cycle phase ran during hold");

  property p_first;
    $fell(CORE_RST) ##1 !CORE_RST [*3] |-> CYCLE_STB;
  endproperty
  a_first: assert property (p_first) else $error("first cycle late after hold");

  property p_clear;
    !clear_hi |=> CORE_RST;
  endproperty
  a_clear: assert property (p_clear) else $error("core ran with clear low");

  property p_start;
    $rose(clear_hi) |-> CORE_RST [*4];
  endproperty
  a_start: assert property (p_start) else $error("no hold after clear");

  // Glitches shorter than two samples must not move the clear level
  property p_sync_hold;
    g_sync[0].s_r[1] != g_sync[0].s_r[2] |=> $stable(clear_hi);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("clear level not filtered");

  property p_tick_sync;
    rc_tick |-> g_sync[1].s_r[1] && g_sync[1].s_r[2];
  endproperty
  a_tick_sync: assert property (p_tick_sync) else $error("RC tick not filtered");

  property p_wdt;
    WATCHDOG_TIMEOUT && clear_hi |=> CORE_RST [*3];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not hold");

  property p_wdt_pc;
    WATCHDOG_TIMEOUT && clear_hi |-> ##2 PC == pcr_pkg::PC_RST;
  endproperty
  a_wdt_pc: assert property (p_wdt_pc) else $error("watchdog left counter");

  c_jump: cover property (step && is_jump);
  c_call: cover property (step && is_call);
  c_loww: cover property (step && low_wr);
  c_free: cover property ($fell(CORE_RST));
  c_rtrg: cover property (WATCHDOG_TIMEOUT && clear_hi && CORE_RST);
endmodule
`default_nettype wire

//--- pkg/pcr_pkg.sv
`default_nettype none
package pcr_pkg;
  // ---------------------------------------------------------------
  // Program counter layout
  // ---------------------------------------------------------------
  localparam int          PC_W      = 11;
  localparam logic [10:0] PC_RST    = 11'h7ff;
  localparam int          PAGE_LSB  = 9;
  localparam int          IW_W      = 12;
  // ---------------------------------------------------------------
  // Instruction field codes
  // ---------------------------------------------------------------
  localparam logic [2:0]  OPC_JUMP  = 3'h5;
  localparam logic [3:0]  OPC_CALL  = 4'h9;
  localparam logic [6:0]  OPC_MOVE_W  = 7'h01;
  localparam logic [5:0]  OPC_ADD_W   = 6'h07;
  localparam logic [3:0]  OPC_BIT_SET = 4'h5;
  localparam logic [4:0]  LOW_ADDR    = 5'h02;
  localparam logic [2:0]  LOW_BIT     = 3'h5;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [1:0]  Q_LAST    = 2'h3;
  localparam int          HOLD_MS   = 18;
  localparam int          RC_HZ     = 1000000;
  localparam int          HOLD_TICKS = HOLD_MS * (RC_HZ / 1000);
  localparam int          CNT_W     = 24;
  localparam logic [23:0] CNT_ONE   = 24'h000001;
  // ---------------------------------------------------------------
  // Hold timer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_WAIT, ST_COUNT, ST_RUN} pcr_state_t;
endpackage
`default_nettype wire

//--- hw/pcr_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_hold_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        clear_hi,
  input  wire logic        trig,
  input  wire logic [23:0] hold_ticks,
  output logic             busy
);
  pcr_pkg::pcr_state_t st_r, st_nxt;
  logic [23:0]         cnt_r, cnt_nxt;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    if (!clear_hi) begin
      st_nxt  = pcr_pkg::ST_WAIT;
      cnt_nxt = '0;
    end else if (trig) begin
      // Retrigger restarts from zero
      st_nxt  = pcr_pkg::ST_COUNT;
      cnt_nxt = '0;
    end else begin
      case (st_r)
        pcr_pkg::ST_WAIT: begin
          st_nxt  = pcr_pkg::ST_COUNT;
          cnt_nxt = '0;
        end
        pcr_pkg::ST_COUNT: begin
          // Counts RC edges only, never core cycles
          if (tick) begin
            if (cnt_r == hold_ticks - pcr_pkg::CNT_ONE) begin
              st_nxt = pcr_pkg::ST_RUN;
            end else begin
              cnt_nxt = cnt_r + pcr_pkg::CNT_ONE;
            end
          end
        end
        pcr_pkg::ST_RUN: st_nxt = pcr_pkg::ST_RUN;
        default: begin
          st_nxt  = pcr_pkg::ST_WAIT;
          cnt_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r  <= pcr_pkg::ST_WAIT;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign busy = (st_r != pcr_pkg::ST_RUN);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_restart;
    @(posedge clk) disable iff (rst)
    clear_hi && trig |=> st_r == pcr_pkg::ST_COUNT && cnt_r == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("retrigger not restarted");

  property p_rc_only;
    @(posedge clk) disable iff (rst)
    st_r == pcr_pkg::ST_COUNT && clear_hi && !trig && !tick |=> $stable(cnt_r);
  endproperty
  a_rc_only: assert property (p_rc_only) else $error("count moved without RC edge");

  property p_expire;
    @(posedge clk) disable iff (rst)
    st_r == pcr_pkg::ST_COUNT && clear_hi && !trig && tick &&
      cnt_r == hold_ticks - pcr_pkg::CNT_ONE |=> !busy;
  endproperty
  a_expire: assert property (p_expire) else $error("hold did not expire");
endmodule
`default_nettype wire

//--- verification/pcr_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Instruction fetch and decoder stand-in
// ---------------------------------------------------------------
module pcr_fetch_model (
  input  wire logic        clk,
  input  wire logic        stb,
  input  wire logic [11:0] word,
  input  wire logic [7:0]  alu,
  input  wire logic [1:0]  page,
  output logic      [11:0] instr_word,
  output logic      [7:0]  alu_result,
  output logic      [1:0]  status_page
);
  initial begin
    instr_word = 12'h5a5;
    alu_result = 8'h3c;
    status_page = 2'h2;
  end
  // Off-strobe the bus churns, so sampling on the wrong cycle shows up
  always @(negedge clk) begin
    if (stb) begin
      instr_word <= word;
      alu_result <= alu;
      status_page <= page;
    end else begin
      instr_word <= ~instr_word;
      alu_result <= ~alu_result;
      status_page <= ~status_page;
    end
  end
endmodule
`default_nettype wire

//--- verification/pcr_program_counter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_program_counter_tb;
  localparam int HT = 4;
  logic        clk, sys_rst, run_pin, rc, wd_to, core_rst, cyc_stb;
  logic [11:0] p_word, instr_word;
  logic [7:0]  p_alu, alu_result, low_byte;
  logic [1:0]  p_page, status_page;
  logic [10:0] cnt_o;
  int          n_fail, n_checks, lat;

  pcr_program_counter #(.HOLD_TICKS(HT)) u_dut (.CLK(clk), .SYS_RST(sys_rst),
    .MASTER_CLEAR_PIN(run_pin), .RC_OSC_PIN(rc), .WATCHDOG_TIMEOUT(wd_to),
    .INSTR_WORD(instr_word), .ALU_RESULT(alu_result), .STATUS_PAGE(status_page),
    .PC(cnt_o), .PC_LOW_BYTE(low_byte),
    .CORE_RST(core_rst), .CYCLE_STB(cyc_stb));
  pcr_fetch_model u_fetch (.clk(clk), .stb(cyc_stb), .word(p_word), .alu(p_alu),
    .page(p_page), .instr_word(instr_word), .alu_result(alu_result),
    .status_page(status_page));

  // ---------------------------------------------------------------
  // Clocks and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Free-running RC source, ten system clocks per period
  initial begin
    rc = 1'b0;
    forever begin
      repeat (5) @(negedge clk);
      rc = ~rc;
    end
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    test_done();
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Cycles until the core leaves reset; strobes must stay quiet meanwhile
  task automatic wait_rel(output int n);
    n = 0;
    while (core_rst !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
      if (core_rst === 1'b1) chk({10'h000, cyc_stb}, 11'h000);
    end
  endtask
  task automatic exec(input logic [11:0] w, input logic [7:0] a, input logic [1:0] pg,
                      input logic [10:0] exp, input bit gap);
    int k;
    p_word = w;
    p_alu = a;
    p_page = pg;
    k = 0;
    while (cyc_stb !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    if (gap) chk(11'(k), 11'h003);
    @(posedge clk);
    @(negedge clk);
    chk(cnt_o, exp);
    chk({3'h0, low_byte}, {3'h0, exp[7:0]});
  endtask
  task automatic wd_pulse;
    wd_to = 1'b1;
    @(negedge clk);
    wd_to = 1'b0;
    @(negedge clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_power_up;
    chk(cnt_o, 11'h7ff);
    chk({10'h000, core_rst}, 11'h001);
    repeat (10) @(negedge clk);
    chk({10'h000, core_rst}, 11'h001);
    run_pin = 1'b1;
    wait_rel(lat);
    chk(11'(lat >= 30 && lat <= 60), 11'h001);
  endtask
  task automatic t_loads;
    exec(12'h000, 8'h00, 2'h0, 11'h000, 1'b0);
    exec(12'h000, 8'h00, 2'h0, 11'h001, 1'b1);
    exec(12'ha05, 8'h00, 2'h1, 11'h205, 1'b1);
    exec(12'hbff, 8'h00, 2'h3, 11'h7ff, 1'b1);
    exec(12'h000, 8'h00, 2'h3, 11'h000, 1'b1);
    exec(12'h9ab, 8'h00, 2'h2, 11'h4ab, 1'b1);
    exec(12'h022, 8'h3c, 2'h1, 11'h23c, 1'b1);
    exec(12'h1e2, 8'h80, 2'h0, 11'h080, 1'b1);
    exec(12'h5a2, 8'hff, 2'h3, 11'h6ff, 1'b1);
    exec(12'h1c2, 8'h00, 2'h0, 11'h700, 1'b1);
  endtask
  task automatic t_watchdog;
    wd_pulse();
    chk({10'h000, core_rst}, 11'h001);
    chk(cnt_o, 11'h7ff);
    repeat (20) @(negedge clk);
    wd_pulse();
    wait_rel(lat);
    chk(11'(lat >= 28 && lat <= 60), 11'h001);
    exec(12'h000, 8'h00, 2'h0, 11'h000, 1'b0);
  endtask
  task automatic t_clear_low;
    run_pin = 1'b0;
    repeat (6) @(negedge clk);
    chk({10'h000, core_rst}, 11'h001);
    chk(cnt_o, 11'h7ff);
    run_pin = 1'b1;
    wait_rel(lat);
    chk(11'(lat >= 30 && lat <= 60), 11'h001);
  endtask

  initial begin
    n_fail = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    run_pin = 1'b0;
    wd_to = 1'b0;
    p_word = 12'h000;
    p_alu = 8'h00;
    p_page = 2'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    t_power_up();
    t_loads();
    t_watchdog();
    t_clear_low();
    test_done();
  end
endmodule
`default_nettype wire
